// >>> common/host_pins_pkg.sv
/*
  Shared types and constants for the host serial pin mux and status block.
  Assumes a single 200 MHz core clock domain; serial pins arrive asynchronously.
*/
package host_pins_pkg;

    localparam int SYNC_STAGES = 2;
    localparam logic IFSEL_SPI = 1'b0;
    localparam logic IFSEL_I2C = 1'b1;

    // DPLL operating mode as reported by the loop core
    typedef enum logic [1:0] {
        DPLL_NORMAL   = 2'b00,
        DPLL_FREERUN  = 2'b01,
        DPLL_HOLDOVER = 2'b10
    } dpll_mode_e;

    // Loop status bundle from the DPLL core
    typedef struct packed {
        logic       freq_locked;
        logic       phase_locked;
        dpll_mode_e mode;
    } dpll_status_s;

    // Synchronised view of the SPI pins towards the protocol engine
    typedef struct packed {
        logic sck;
        logic si;
        logic cs_n;
    } spi_pins_s;

    // Synchronised view of the I2C pins towards the protocol engine
    typedef struct packed {
        logic scl;
        logic sda;
        logic addr_bit0;
    } i2c_pins_s;

    // Bit positions of the pins inside the synchroniser bank
    localparam int PIN_COUNT = 4;
    localparam int PIN_SEL   = 3;
    localparam int PIN_CLK   = 2;
    localparam int PIN_DATA  = 1;
    localparam int PIN_CSA   = 0;

    // Synchroniser reset level: strap pull-up and idle-high serial lines
    localparam logic PIN_IDLE = 1'b1;

    // Edges after reset release before the strap level is taken
    localparam int STRAP_WAIT = SYNC_STAGES;

    // Views shown for the interface that is not selected
    localparam spi_pins_s SPI_IDLE = 3'h3;
    localparam i2c_pins_s I2C_IDLE = 3'h6;

endpackage : host_pins_pkg

// >>> design/host_serial_select_and_status.sv
/*
  Pin mux for the shared host serial pins, lock and holdover indicators,
  and the open-drain interrupt line.
  Assumes the serial protocol engines and the status/interrupt registers sit
  outside on sys_clk; pins are asynchronous and pass two flip-flops first.
*/
`timescale 1ns/1ps
module host_serial_select_and_status
    import host_pins_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          i2c_select_pin,
    input  wire logic          clk_pin_in,
    output logic               clk_pin_out,
    output logic               clk_pin_oe,
    input  wire logic          data_pin_in,
    output logic               data_pin_out,
    output logic               data_pin_oe,
    output logic               serial_out_pin,
    input  wire logic          select_or_addr_bit0_pin,
    output logic               irq_n_out,
    output logic               irq_n_oe,
    output logic               lock_pin,
    output logic               hold_pin,
    input  wire dpll_status_s  dpll_status,
    input  wire logic          spi_read_data,
    input  wire logic          spi_read_drive,
    input  wire logic          i2c_scl_pull_low,
    input  wire logic          i2c_sda_pull_low,
    input  wire logic [7:0]    irq_pending,
    input  wire logic [7:0]    irq_enable,
    output logic               i2c_mode,
    output spi_pins_s          spi_pins,
    output i2c_pins_s          i2c_pins
);

    // Pin positions are fixed so one loop can synchronise every pin
    wire [PIN_COUNT-1:0] raw_pins;
    wire [PIN_COUNT-1:0] sync_q;

    assign raw_pins[PIN_SEL]  = i2c_select_pin;
    assign raw_pins[PIN_CLK]  = clk_pin_in;
    assign raw_pins[PIN_DATA] = data_pin_in;
    assign raw_pins[PIN_CSA]  = select_or_addr_bit0_pin;

    // Two flops per pin; stage one is read only by stage two
    for (genvar p = 0; p < PIN_COUNT; p++)
    begin : g_sync
        logic meta;
        logic held;

        // Idle-high reset, so no false edge follows release
        always_ff @(posedge sys_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                meta <= PIN_IDLE;
                held <= PIN_IDLE;
            end
            else
            begin
                meta <= raw_pins[p];
                held <= meta;
            end
        end

        assign sync_q[p] = held;
    end

    // Synchronised pin levels by job
    wire sel_s  = sync_q[PIN_SEL];
    wire clk_s  = sync_q[PIN_CLK];
    wire data_s = sync_q[PIN_DATA];
    wire csa_s  = sync_q[PIN_CSA];

    // Strap taken once the synchronisers carry the real pin level, not their reset value;
    // later changes are ignored, a live switch would glitch a transfer in flight
    logic [2:0] strap_wait;
    logic       strap_taken;
    logic       mode_i2c;
    wire        strap_due = (strap_wait == 3'(STRAP_WAIT));

    // Edges since release, held once the strap is due
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_wait <= 3'h0;
        end
        else if (!strap_due)
        begin
            strap_wait <= strap_wait + 3'h1;
        end
    end

    // Interface select; I2C until taken, as an open strap would give
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_taken <= 1'b0;
            mode_i2c    <= IFSEL_I2C;
        end
        else if (strap_due && !strap_taken)
        begin
            strap_taken <= 1'b1;
            mode_i2c    <= (sel_s == IFSEL_I2C);
        end
    end

    // Live view while its interface is selected, fixed idle pattern otherwise
    function automatic logic [2:0] view_or_idle
    (
        input logic       selected,
        input logic [2:0] live,
        input logic [2:0] idle
    );
        return selected ? live : idle;
    endfunction : view_or_idle

    // Next values of the registered outputs
    wire            any_irq     = |(irq_pending & irq_enable);
    wire            next_lock   = dpll_status.freq_locked & dpll_status.phase_locked;
    wire            next_hold   = (dpll_status.mode == DPLL_HOLDOVER);
    wire            next_scl_oe = mode_i2c & i2c_scl_pull_low;
    wire            next_sda_oe = mode_i2c & i2c_sda_pull_low;
    wire            next_so     = ~mode_i2c & spi_read_drive & spi_read_data;
    wire [2:0]      live_view   = {clk_s, data_s, csa_s};
    wire spi_pins_s next_spi    = spi_pins_s'(view_or_idle(~mode_i2c, live_view, SPI_IDLE));
    wire i2c_pins_s next_i2c    = i2c_pins_s'(view_or_idle(mode_i2c, live_view, I2C_IDLE));

    // Loop indicators, one cycle behind the loop status
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_pin <= 1'b0;
            hold_pin <= 1'b0;
        end
        else
        begin
            lock_pin <= next_lock;
            hold_pin <= next_hold;
        end
    end

    // Shared pin pull-downs; SPI mode never drives these pins
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_pin_oe  <= 1'b0;
            data_pin_oe <= 1'b0;
        end
        else
        begin
            clk_pin_oe  <= next_scl_oe;
            data_pin_oe <= next_sda_oe;
        end
    end

    // Serial read data, forced low in I2C where the pin has no job
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serial_out_pin <= 1'b0;
        end
        else
        begin
            serial_out_pin <= next_so;
        end
    end

    // Interrupt pull-down stays on while any enabled source is pending
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_n_oe <= 1'b0;
        end
        else
        begin
            irq_n_oe <= any_irq;
        end
    end

    // Selected interface for the protocol engines
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            i2c_mode <= IFSEL_I2C;
        end
        else
        begin
            i2c_mode <= mode_i2c;
        end
    end

    // Pin views; the unselected engine sees its idle bus
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            spi_pins <= SPI_IDLE;
            i2c_pins <= I2C_IDLE;
        end
        else
        begin
            spi_pins <= next_spi;
            i2c_pins <= next_i2c;
        end
    end

    // Constant-low drive values; the enables alone decide the wire level
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_pin_out  <= 1'b0;
            data_pin_out <= 1'b0;
            irq_n_out    <= 1'b0;
        end
        else
        begin
            clk_pin_out  <= 1'b0;
            data_pin_out <= 1'b0;
            irq_n_out    <= 1'b0;
        end
    end

endmodule : host_serial_select_and_status

// >>> test/host_model.sv
/* Host serial master: one 8-bit frame per rise of run; assumes pull-ups on lines. */
`timescale 1ns/1ps
module host_model
(
    input  wire logic run,
    output logic      sck,
    output logic      sd,
    output logic      cs_n
);
    initial {sck, sd, cs_n} = 3'h7;
    // Clock idles high between frames; data moves on the fall so it is steady at each rise
    always @(posedge run)
    begin
        cs_n = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            #24 sck = 1'b0;
            sd = i[0];
            #24 sck = 1'b1;
        end
        // Last bit held a half period, then lines go back to their pull-up level
        #24 cs_n = 1'b1;
        sd = 1'b1;
    end
endmodule : host_model

// >>> test/host_pins_assertions.sv
/* Checker for the host pin mux; bound to the top module, sees its ports. */
`timescale 1ns/1ps
module host_pins_assertions
    import host_pins_pkg::*;
(
    input wire logic sys_clk, rst_n, clk_pin_in, data_pin_in, select_or_addr_bit0_pin,
    input wire logic clk_pin_out, clk_pin_oe, data_pin_out, data_pin_oe, serial_out_pin,
    input wire logic irq_n_out, irq_n_oe, lock_pin, hold_pin, i2c_mode,
    input wire logic spi_read_data, spi_read_drive, i2c_scl_pull_low, i2c_sda_pull_low,
    input wire logic [7:0] irq_pending, irq_enable,
    input wire dpll_status_s dpll_status,
    input wire spi_pins_s spi_pins,
    input wire i2c_pins_s i2c_pins
);
    logic [2:0] up;
    wire ready = (up == 3'h7); // Mode latched and synchronisers filled
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Edges since release, saturating
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n) up <= 3'h0;
        else if (!ready) up <= up + 3'h1;
    lock_out_a: assert property (1 |=> lock_pin ==
        ($past(dpll_status.freq_locked) & $past(dpll_status.phase_locked)))
        else $error("lock output wrong");
    hold_out_a: assert property (1 |=> hold_pin == ($past(dpll_status.mode) == DPLL_HOLDOVER))
        else $error("holdover output wrong");
    scl_drive_a: assert property (ready && i2c_mode |-> clk_pin_oe == $past(i2c_scl_pull_low))
        else $error("scl pull wrong");
    sda_drive_a: assert property (ready && i2c_mode |-> data_pin_oe == $past(i2c_sda_pull_low))
        else $error("sda pull wrong");
    spi_quiet_a: assert property (ready && !i2c_mode |-> !clk_pin_oe && !data_pin_oe)
        else $error("shared pin driven in spi mode");
    so_drive_a: assert property (ready |-> serial_out_pin ==
        (!i2c_mode && $past(spi_read_drive) && $past(spi_read_data)))
        else $error("serial out wrong");
    spi_sync_a: assert property (ready && !i2c_mode |-> spi_pins ==
        {$past(clk_pin_in, 3), $past(data_pin_in, 3), $past(select_or_addr_bit0_pin, 3)})
        else $error("spi pin view wrong");
    i2c_sync_a: assert property (ready && i2c_mode |-> i2c_pins ==
        {$past(clk_pin_in, 3), $past(data_pin_in, 3), $past(select_or_addr_bit0_pin, 3)})
        else $error("i2c pin view wrong");
    spi_idle_a: assert property (ready && i2c_mode |-> spi_pins == 3'h3)
        else $error("spi view not idle");
    i2c_idle_a: assert property (ready && !i2c_mode |-> i2c_pins == 3'h6)
        else $error("i2c view not idle");
    irq_level_a: assert property (1 |=> irq_n_oe == |($past(irq_pending) & $past(irq_enable)))
        else $error("interrupt line wrong");
    open_drain_a: assert property (!irq_n_out && !clk_pin_out && !data_pin_out)
        else $error("pin driven high");
endmodule : host_pins_assertions
bind host_serial_select_and_status host_pins_assertions chk (.*);

// >>> test/tb_top.sv
/* Bench for the host pin mux; host model drives the shared pins through pull-ups. */
`timescale 1ns/1ps
module tb_top;
    import host_pins_pkg::*;
    logic sys_clk = 0, rst_n = 0, strap = 1, rd = 0, rdrv = 0, scl_pl = 0, sda_pl = 0, run = 0;
    logic [7:0] pend = 8'h00, en = 8'h00;
    dpll_status_s st = '0;
    logic sck, sd, cs_n, clk_oe, dat_oe, so, irq_oe, lock, hold, mode;
    spi_pins_s spi;
    i2c_pins_s i2c;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    wire scl_line = sck & ~clk_oe; // Wired-AND with pull-up
    wire sda_line = sd & ~dat_oe;
    host_model host (.run(run), .sck(sck), .sd(sd), .cs_n(cs_n));
    host_serial_select_and_status DUT (.sys_clk(sys_clk), .rst_n(rst_n), .i2c_select_pin(strap),
        .clk_pin_in(scl_line), .clk_pin_out(), .clk_pin_oe(clk_oe), .data_pin_in(sda_line), .data_pin_out(),
        .data_pin_oe(dat_oe), .serial_out_pin(so), .select_or_addr_bit0_pin(cs_n), .irq_n_out(), .irq_n_oe(irq_oe),
        .lock_pin(lock), .hold_pin(hold), .dpll_status(st), .spi_read_data(rd), .spi_read_drive(rdrv),
        .i2c_scl_pull_low(scl_pl), .i2c_sda_pull_low(sda_pl), .irq_pending(pend), .irq_enable(en),
        .i2c_mode(mode), .spi_pins(spi), .i2c_pins(i2c));
    initial forever #2.5 sys_clk = ~sys_clk;
    // Hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk) if (++cyc == 3000) begin n_mismatch++; report_and_stop(); end
    task automatic chk(string what, logic exp, logic got);
        n_compared++;
        if (got !== exp) begin n_mismatch++; $display("mismatch %s expected %b seen %b", what, exp, got); end
    endtask : chk
    task automatic step(int n); repeat (n) @(negedge sys_clk); endtask : step
    task automatic restart(logic s); rst_n = 0; strap = s; step(2); rst_n = 1; step(6); endtask : restart
    task automatic t_status;
        for (int i = 0; i < 16; i++) begin st = dpll_status_s'(4'(i)); step(2);
            chk("lock", st.freq_locked & st.phase_locked, lock);
            chk("hold", st.mode == DPLL_HOLDOVER, hold); end
    endtask : t_status
    task automatic t_irq;
        pend = 8'h81; en = 8'h80; step(2); chk("irq", 1, irq_oe);
        pend = 8'h01;
        step(2); chk("irq", 0, irq_oe);
        pend = 8'h80; step(2); chk("irq", 1, irq_oe);
        pend = 8'h00; step(2); chk("irq", 0, irq_oe);
    endtask : t_irq
    task automatic t_i2c;
        restart(1); chk("mode", 1, mode);
        scl_pl = 1; rd = 1; rdrv = 1; step(2); chk("scl", 0, scl_line);
        chk("sda_oe", 0, dat_oe);
        sda_pl = 1; step(2); chk("sda", 0, sda_line);
        chk("so", 0, so);
        scl_pl = 0; sda_pl = 0; step(4); chk("addr", cs_n, i2c.addr_bit0);
        chk("scl_in", 1, i2c.scl);
        run = 1; step(18); chk("addr", 0, i2c.addr_bit0);
        chk("scl_in", 0, i2c.scl);
        step(86); run = 0; step(2); chk("addr", 1, i2c.addr_bit0);
    endtask : t_i2c
    task automatic t_spi;
        restart(0); chk("mode", 0, mode);
        scl_pl = 1; sda_pl = 1; step(2); chk("scl_oe", 0, clk_oe);
        chk("sda_oe", 0, dat_oe);
        chk("so", 1, so);
        run = 1; step(24); chk("cs", 0, spi.cs_n);
        step(80); run = 0; rdrv = 0; step(2); chk("cs", 1, spi.cs_n);
        chk("so", 0, so);
    endtask : t_spi
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    initial begin restart(1); t_status(); t_irq(); t_i2c(); t_spi(); report_and_stop(); end
endmodule : tb_top
